// ===== rtl/clock_monitor.sv
`timescale 1ns/10ps
module clock_monitor import rst_pkg::*; #(
  parameter int TIMEOUT = CMON_TIMEOUT_CYC
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic enable_in,
  input wire logic activity_in,
  output logic fail_out
);
  logic sync0_ff, sync1_ff, last_ff;
  logic [CNT_W-1:0] idle_ff, nxt_idle;
  logic fail_ff, nxt_fail;
  logic edge_seen;

  // The guarded clock is foreign, so it passes two flops before edge detection.
  assign edge_seen = sync1_ff ^ last_ff;

  // Idle time since the last edge on a free timebase; each edge restarts it.
  always_comb begin
    nxt_idle = idle_ff;
    if (edge_seen || !enable_in) begin
      nxt_idle = '0; // see R28
    end else if (idle_ff != CNT_W'(TIMEOUT)) begin
      nxt_idle = CNT_W'(idle_ff + 1'b1);
    end
    nxt_fail = enable_in && nxt_idle == CNT_W'(TIMEOUT); // see R14
  end

  // A stopped clock holds the count at its end so the failure stays asserted.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sync0_ff <= 1'b0;
      sync1_ff <= 1'b0;
      last_ff <= 1'b0;
      idle_ff <= '0;
      fail_ff <= 1'b0;
    end else begin
      sync0_ff <= activity_in;
      sync1_ff <= sync0_ff;
      last_ff <= sync1_ff;
      idle_ff <= nxt_idle;
      fail_ff <= nxt_fail;
    end
  end

  assign fail_out = fail_ff;

  a_monitor_quiet: assert property ( // see R15
    @(posedge clk_sys_in) disable iff (srst_in)
    edge_seen |=> !fail_out)
    else $error("clock monitor failed right after a clock edge");
endmodule

// ===== rtl/reset_watchdog_clock_monitor.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module reset_watchdog_clock_monitor import rst_pkg::*; #(
  parameter int WDG_PRESCALE = WDG_PRESCALE_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_out,
  input wire logic special_mode_flag_in,
  input wire logic cpu_clk_activity_in,
  input wire logic stop_mode_in,
  input wire logic irq_pin_in,
  input wire logic irq_ack_in,
  input wire logic [7:0] nvm_config_in,
  output logic nvm_write_out,
  output logic [7:0] nvm_write_data_out,
  output logic sys_reset_out,
  output logic [15:0] reset_vector_out,
  output logic converter_power_up_out,
  output logic converter_clock_source_out,
  output logic irq_request_out,
  output logic osc_hold_out
);
  seq_state_type state_ff, nxt_state;
  reset_cause_type cause_ff, nxt_cause;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic pin_s0_ff, pin_s1_ff;
  logic mode_s0_ff, mode_s1_ff;
  logic irq_s0_ff, irq_s1_ff, irq_prev_ff;
  logic int_rst;
  logic wdg_timeout, wdg_reset, cmon_fail, mon_en;
  logic wr_en, setup;
  logic [7:0] wdata;

  // Foreign pins pass two flops before any logic reads them.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pin_s0_ff <= 1'b1;
      pin_s1_ff <= 1'b1;
      mode_s0_ff <= 1'b0;
      mode_s1_ff <= 1'b0;
      irq_s0_ff <= 1'b1;
      irq_s1_ff <= 1'b1;
      irq_prev_ff <= 1'b1;
    end else begin
      pin_s0_ff <= reset_pin_in;
      pin_s1_ff <= pin_s0_ff;
      mode_s0_ff <= special_mode_flag_in;
      mode_s1_ff <= mode_s0_ff;
      irq_s0_ff <= irq_pin_in;
      irq_s1_ff <= irq_s0_ff;
      irq_prev_ff <= irq_s1_ff;
    end
  end

  // Reset sequencer. The settle wait adds the synchroniser depth, so the pin
  // value judged is the one on the pin two cycles after release.
  always_comb begin
    nxt_state = state_ff;
    nxt_cause = cause_ff;
    nxt_cnt = CNT_W'(cnt_ff + 1'b1);
    case (state_ff)
      ST_POR: begin
        if (cnt_ff == POR_LAST) begin // see R1
          nxt_state = ST_DRIVE;
          nxt_cause = CAUSE_POR_PIN;
          nxt_cnt = '0;
        end
      end
      ST_DRIVE: begin
        if (cnt_ff == DRIVE_LAST) begin // see R4
          nxt_state = ST_SETTLE;
          nxt_cnt = '0;
        end
      end
      ST_SETTLE: begin
        nxt_cnt = CNT_W'(cnt_ff + 1'b1);
        if (cnt_ff == SAMPLE_LAST) begin // see R5
          nxt_cnt = '0;
          if (!pin_s1_ff) begin
            // A slow RC on the pin would be misread here as external.
            nxt_state = ST_EXT_WAIT; // see R6
            nxt_cause = CAUSE_POR_PIN;
          end else begin
            nxt_state = ST_RUN;
          end
        end
      end
      ST_EXT_WAIT: begin
        nxt_cnt = '0;
        if (pin_s1_ff) begin // see R2
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_cnt = '0;
        // Priority is pin, then clock monitor, then watchdog.
        if (!pin_s1_ff) begin // see R3
          nxt_state = ST_DRIVE;
          nxt_cause = CAUSE_POR_PIN;
        end else if (cmon_fail) begin
          nxt_state = ST_DRIVE;
          nxt_cause = CAUSE_CLOCK_MON;
        end else if (wdg_reset) begin
          nxt_state = ST_DRIVE;
          nxt_cause = CAUSE_WATCHDOG;
        end
      end
      default: begin
        nxt_state = ST_POR;
        nxt_cnt = '0;
      end
    endcase
  end

  // Sequencer registers; the power-on count starts from the reset release.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_ff <= ST_POR;
      cause_ff <= CAUSE_POR_PIN;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cause_ff <= nxt_cause;
      cnt_ff <= nxt_cnt;
    end
  end

  assign int_rst = srst_in || state_ff != ST_RUN;
  assign sys_reset_out = state_ff != ST_RUN;
  assign reset_pin_oe_out = state_ff == ST_DRIVE; // see R4
  assign reset_pin_out = 1'b0;

  // Register file state.
  logic [7:0] opt_ff, nxt_opt;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [CNT_W-1:0] prot_cnt_ff, nxt_prot_cnt;
  logic prot_open_ff, nxt_prot_open;
  logic special_ff, nxt_special;
  logic dis_rst_ff, nxt_dis_rst;
  logic nvm_wr_ff, nxt_nvm_wr;
  logic [7:0] nvm_data_ff, nxt_nvm_data;
  logic [7:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err;
  logic opt_open;

  assign setup = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign wdata = pwdata_in[7:0];
  assign opt_open = special_ff || prot_open_ff;

  // Register writes and reset loads. The protected option bits take one write
  // in the first 64 cycles of normal mode; that guards against stray code.
  always_comb begin
    nxt_opt = opt_ff;
    nxt_cfg = cfg_ff;
    nxt_special = special_ff;
    nxt_dis_rst = dis_rst_ff;
    nxt_nvm_wr = 1'b0;
    nxt_nvm_data = nvm_data_ff;
    nxt_prot_open = prot_open_ff;
    nxt_prot_cnt = CNT_W'(prot_cnt_ff + 1'b1);
    if (int_rst) begin
      nxt_opt = OPTIONS_RESET; // see R11
      nxt_cfg = nvm_config_in; // see R24
      nxt_special = mode_s1_ff;
      nxt_dis_rst = mode_s1_ff; // see R9
      nxt_prot_open = 1'b1;
      nxt_prot_cnt = '0;
    end else begin
      if (prot_cnt_ff == PROTECT_LAST) begin
        nxt_prot_open = 1'b0; // see R19
        nxt_prot_cnt = prot_cnt_ff;
      end
      if (wr_en && paddr_in == ADDR_OPTIONS) begin
        // Power, clock source and monitor enable are writable at any time.
        nxt_opt = (opt_ff & PROTECT_MASK) | (wdata & ~PROTECT_MASK); // see R17
        if (opt_open) begin
          nxt_opt = wdata; // see R19
          nxt_prot_open = 1'b0;
        end
        nxt_opt[OPT_FORCE_MON] = nxt_opt[OPT_FORCE_MON] || opt_ff[OPT_FORCE_MON]; // see R18
      end
      if (wr_en && paddr_in == ADDR_CONFIG) begin
        if (special_ff) begin
          nxt_cfg = wdata; // see R25
        end else begin
          nxt_nvm_wr = 1'b1; // see R23
          nxt_nvm_data = wdata;
        end
      end
      if (wr_en && paddr_in == ADDR_TEST) begin
        nxt_dis_rst = wdata[TEST_DISABLE_RESETS]; // see R9
      end
    end
  end

  // Read data and error are captured in the setup phase for a zero-wait access.
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_err = 1'b0;
      case (paddr_in)
        ADDR_OPTIONS: nxt_rdata = opt_ff;
        ADDR_SERVICE: nxt_rdata = 8'h00;
        ADDR_STATUS: nxt_rdata = {5'h00, special_ff, cause_ff};
        ADDR_TEST: nxt_rdata = {7'h00, dis_rst_ff};
        ADDR_CONFIG: nxt_rdata = cfg_ff | CONFIG_ONES; // see R24
        default: begin
          nxt_rdata = 8'h00;
          nxt_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      opt_ff <= OPTIONS_RESET;
      cfg_ff <= 8'hff;
      prot_cnt_ff <= '0;
      prot_open_ff <= 1'b1;
      special_ff <= 1'b0;
      dis_rst_ff <= 1'b0;
      nvm_wr_ff <= 1'b0;
      nvm_data_ff <= 8'h00;
      rdata_ff <= 8'h00;
      err_ff <= 1'b0;
    end else begin
      opt_ff <= nxt_opt;
      cfg_ff <= nxt_cfg;
      prot_cnt_ff <= nxt_prot_cnt;
      prot_open_ff <= nxt_prot_open;
      special_ff <= nxt_special;
      dis_rst_ff <= nxt_dis_rst;
      nvm_wr_ff <= nxt_nvm_wr;
      nvm_data_ff <= nxt_nvm_data;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  assign pready_out = psel_in && penable_in;
  assign pslverr_out = psel_in && penable_in && err_ff;
  assign prdata_out = {24'h000000, rdata_ff};
  assign nvm_write_out = nvm_wr_ff;
  assign nvm_write_data_out = nvm_data_ff;
  assign converter_power_up_out = opt_ff[OPT_CONV_POWER]; // see R22
  assign converter_clock_source_out = opt_ff[OPT_CONV_CLOCK]; // see R22

  // Watchdog and clock monitor. Stop halts the guarded clock, so an enabled
  // monitor trips there; software must clear the enable first.
  assign mon_en = opt_ff[OPT_MON_EN] || opt_ff[OPT_FORCE_MON]; // see R16
  assign wdg_reset = wdg_timeout && !(special_ff && dis_rst_ff); // see R9

  watchdog_timer #(
    .PRESCALE(WDG_PRESCALE)
  ) u_watchdog (
    .clk_sys_in(clk_sys_in),
    .srst_in(int_rst),
    .enable_in(!cfg_ff[CFG_WDG_DISABLE]), // see R8 see R26
    .rate_in(opt_ff[1:0]),
    .service_write_in(wr_en && paddr_in == ADDR_SERVICE),
    .service_data_in(wdata),
    .timeout_out(wdg_timeout)
  );

  clock_monitor #(
    .TIMEOUT(CMON_TIMEOUT_CYC) // see R15
  ) u_clock_monitor (
    .clk_sys_in(clk_sys_in),
    .srst_in(int_rst),
    .enable_in(mon_en), // see R14
    .activity_in(cpu_clk_activity_in),
    .fail_out(cmon_fail)
  );

  // Vector select, stop-exit delay and interrupt sensing.
  logic [15:0] vec_ff, nxt_vec;
  logic stop_prev_ff;
  logic hold_ff, nxt_hold;
  logic [CNT_W-1:0] hold_cnt_ff, nxt_hold_cnt;
  logic irq_latch_ff, nxt_irq_latch;
  logic irq_req_ff, nxt_irq_req;

  always_comb begin
    case (cause_ff)
      CAUSE_CLOCK_MON: nxt_vec = special_ff ? VEC_SPEC_CMON : VEC_NORM_CMON; // see R27
      CAUSE_WATCHDOG: nxt_vec = special_ff ? VEC_SPEC_WDG : VEC_NORM_WDG;
      default: nxt_vec = special_ff ? VEC_SPEC_PIN : VEC_NORM_PIN;
    endcase
    nxt_hold = hold_ff;
    nxt_hold_cnt = CNT_W'(hold_cnt_ff + 1'b1);
    if (stop_prev_ff && !stop_mode_in && opt_ff[OPT_STOP_DELAY]) begin
      nxt_hold = 1'b1; // see R20
      nxt_hold_cnt = '0;
    end else if (hold_ff && hold_cnt_ff == STOP_DELAY_LAST) begin
      nxt_hold = 1'b0;
    end
    // A falling edge arriving with the acknowledge still sets the latch.
    nxt_irq_latch = irq_latch_ff && !irq_ack_in;
    if (irq_prev_ff && !irq_s1_ff) begin
      nxt_irq_latch = 1'b1;
    end
    nxt_irq_req = opt_ff[OPT_EDGE_SENSE] ? nxt_irq_latch : !irq_s1_ff; // see R21
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      vec_ff <= VEC_NORM_PIN;
      stop_prev_ff <= 1'b0;
      hold_ff <= 1'b0;
      hold_cnt_ff <= '0;
      irq_latch_ff <= 1'b0;
      irq_req_ff <= 1'b0;
    end else begin
      vec_ff <= nxt_vec;
      stop_prev_ff <= stop_mode_in;
      hold_ff <= nxt_hold;
      hold_cnt_ff <= nxt_hold_cnt;
      irq_latch_ff <= nxt_irq_latch;
      irq_req_ff <= nxt_irq_req;
    end
  end

  assign reset_vector_out = vec_ff;
  assign osc_hold_out = hold_ff;
  assign irq_request_out = irq_req_ff;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);

  sequence s_pin_driven;
    reset_pin_oe_out [*4];
  endsequence

  sequence s_pin_released;
    !reset_pin_oe_out;
  endsequence

  a_por_delay: assert property ( // see R1
    state_ff == ST_DRIVE && $past(state_ff) == ST_POR |-> $past(cnt_ff) == POR_LAST)
    else $error("power-on hold left before its full count");

  a_pin_drive_four: assert property ( // see R4
    $rose(reset_pin_oe_out) |-> s_pin_driven ##1 s_pin_released)
    else $error("reset pin not driven for exactly four cycles");

  a_pin_sample: assert property ( // see R5
    $fell(reset_pin_oe_out) |-> ##4 (state_ff == ST_EXT_WAIT || state_ff == ST_RUN))
    else $error("reset pin not judged at the settle point");

  a_ext_hold: assert property ( // see R2
    state_ff == ST_EXT_WAIT && !pin_s1_ff |=> state_ff == ST_EXT_WAIT && sys_reset_out)
    else $error("reset released while the pin is low");

  a_wdg_inhibit: assert property ( // see R9
    state_ff == ST_RUN && pin_s1_ff && !cmon_fail && wdg_timeout && special_ff && dis_rst_ff
    |=> state_ff == ST_RUN)
    else $error("inhibited watchdog still reset the device");

  a_rate_cleared: assert property ( // see R11
    state_ff == ST_DRIVE |=> opt_ff[1:0] == 2'h0 && !opt_ff[OPT_MON_EN])
    else $error("reset did not clear rate and monitor enable");

  a_force_monitor: assert property ( // see R18
    opt_ff[OPT_FORCE_MON] && !int_rst |=> mon_en)
    else $error("forced clock monitor was disabled");

  a_protect_window: assert property ( // see R19
    !int_rst && !opt_open && wr_en && paddr_in == ADDR_OPTIONS
    |=> (opt_ff & PROTECT_MASK & 8'hfb) == ($past(opt_ff) & PROTECT_MASK & 8'hfb))
    else $error("protected option bits changed after the window");

  a_irq_level: assert property ( // see R21
    !opt_ff[OPT_EDGE_SENSE] && !$past(opt_ff[OPT_EDGE_SENSE]) |=> irq_request_out == !$past(irq_s1_ff))
    else $error("level interrupt request does not follow the pin");
endmodule

// ===== rtl/rst_pkg.sv
// Notes on behaviour
// R1: Hold reset 4064 cycles after power-on.
// R2: Stay in reset while pin still low.
// R3: Four sources; pin and power-on share vector.
// R4: Drive reset pin low four cycles.
// R5: Sample pin two cycles after release.
// R6: No slow RC delay on reset pin.
// R7: Software services watchdog before expiry.
// R8: Watchdog enable from latched disable bit.
// R9: Special modes start with watchdog resets inhibited.
// R10: Watchdog period E/2^15 times 1,4,16,64.
// R11: Reset clears watchdog rate to shortest.
// R12: Timeout nominal to one prescaled period longer.
// R13: Write 0x55 arms, 0xaa clears watchdog.
// R14: Clock monitor resets on missing clock edges.
// R15: Below 10 kHz fails, 200 kHz passes.
// R16: Stop with monitor enabled causes reset.
// R17: Monitor enable always writable, reset clears.
// R18: Force bit keeps monitor enabled until reset.
// R19: Protected option bits write once in 64.
// R20: Stop exit delay about 4000 cycles.
// R21: Interrupt input edge or level sensed.
// R22: Converter power and clock source outputs.
// R23: Working latches govern; reads return latches.
// R24: Latches reload at reset; unused read ones.
// R25: Special mode writes latches directly.
// R26: Watchdog disable bit set stops watchdog.
// R27: Distinct vectors per cause and mode.
// R28: Monitor timeout counter, cleared by edges.
package rst_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 12;
  localparam logic [7:0] IDX_OPTIONS = 8'h39;
  localparam logic [7:0] IDX_SERVICE = 8'h3a;
  localparam logic [7:0] IDX_STATUS = 8'h3d;
  localparam logic [7:0] IDX_TEST = 8'h3e;
  localparam logic [7:0] IDX_CONFIG = 8'h3f;
  localparam logic [7:0] ADDR_OPTIONS = 8'(IDX_OPTIONS * 4);
  localparam logic [7:0] ADDR_SERVICE = 8'(IDX_SERVICE * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
  localparam logic [7:0] ADDR_TEST = 8'(IDX_TEST * 4);
  localparam logic [7:0] ADDR_CONFIG = 8'(IDX_CONFIG * 4);
  localparam logic [7:0] OPTIONS_RESET = 8'h10;
  localparam logic [7:0] PROTECT_MASK = 8'h37;
  localparam logic [7:0] CONFIG_ONES = 8'h60;
  localparam int OPT_CONV_POWER = 7;
  localparam int OPT_CONV_CLOCK = 6;
  localparam int OPT_EDGE_SENSE = 5;
  localparam int OPT_STOP_DELAY = 4;
  localparam int OPT_MON_EN = 3;
  localparam int OPT_FORCE_MON = 2;
  localparam int CFG_WDG_DISABLE = 2;
  localparam int TEST_DISABLE_RESETS = 0;
  localparam logic [7:0] SERVICE_ARM = 8'h55;
  localparam logic [7:0] SERVICE_CLEAR = 8'haa;
  localparam int POR_CYCLES = 4064;
  localparam int DRIVE_CYCLES = 4;
  localparam int SETTLE_CYCLES = 2;
  localparam int SYNC_STAGES = 2;
  localparam int PROTECT_CYCLES = 64;
  localparam int STOP_DELAY_CYCLES = 4000;
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYCLES - 1);
  localparam logic [CNT_W-1:0] DRIVE_LAST = CNT_W'(DRIVE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SETTLE_CYCLES + SYNC_STAGES - 1);
  localparam logic [CNT_W-1:0] PROTECT_LAST = CNT_W'(PROTECT_CYCLES - 1);
  localparam logic [CNT_W-1:0] STOP_DELAY_LAST = CNT_W'(STOP_DELAY_CYCLES - 1);
  localparam int CLK_FREQ_MHZ = 100;
  localparam int CMON_TIMEOUT_NS = 10000;
  localparam int CMON_TIMEOUT_CYC = CMON_TIMEOUT_NS * CLK_FREQ_MHZ / 1000;
  localparam int WDG_PRESCALE_DEFAULT = 32768;
  localparam logic [15:0] VEC_NORM_PIN = 16'hfffe;
  localparam logic [15:0] VEC_NORM_CMON = 16'hfffc;
  localparam logic [15:0] VEC_NORM_WDG = 16'hfffa;
  localparam logic [15:0] VEC_SPEC_PIN = 16'hbffe;
  localparam logic [15:0] VEC_SPEC_CMON = 16'hbffc;
  localparam logic [15:0] VEC_SPEC_WDG = 16'hbffa;
  typedef enum logic [1:0] {
    CAUSE_POR_PIN = 2'h0,
    CAUSE_CLOCK_MON = 2'h1,
    CAUSE_WATCHDOG = 2'h2
  } reset_cause_type;
  typedef enum logic [4:0] {
    ST_POR = 5'h01,
    ST_DRIVE = 5'h02,
    ST_SETTLE = 5'h04,
    ST_EXT_WAIT = 5'h08,
    ST_RUN = 5'h10
  } seq_state_type;
endpackage

// ===== rtl/watchdog_timer.sv
`timescale 1ns/10ps
module watchdog_timer import rst_pkg::*; #(
  parameter int PRESCALE = WDG_PRESCALE_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic enable_in,
  input wire logic [1:0] rate_in,
  input wire logic service_write_in,
  input wire logic [7:0] service_data_in,
  output logic timeout_out
);
  logic [15:0] pre_ff, nxt_pre;
  logic [6:0] cnt_ff, nxt_cnt;
  logic armed_ff, nxt_armed;
  logic timeout_ff, nxt_timeout;
  logic tick;
  logic [6:0] limit;
  logic clear_req;

  // Ticks every PRESCALE cycles, 2^15 by default; the limit is 1, 4, 16 or 64 ticks.
  assign tick = (pre_ff == 16'(PRESCALE - 1)); // see R10
  assign limit = 7'(7'h01 << {rate_in, 1'b0}); // see R10
  assign clear_req = service_write_in && service_data_in == SERVICE_CLEAR && armed_ff;

  // The prescaler is not cleared by service, so timing out on tick number limit+1
  // keeps the period at least nominal and at most one tick longer.
  always_comb begin
    nxt_pre = tick ? 16'h0000 : 16'(pre_ff + 16'h0001);
    nxt_cnt = cnt_ff;
    nxt_armed = armed_ff;
    nxt_timeout = enable_in && tick && cnt_ff == limit; // see R12
    if (clear_req) begin
      nxt_cnt = 7'h00; // see R13
      nxt_armed = 1'b0;
    end else if (tick && enable_in) begin
      nxt_cnt = 7'(cnt_ff + 7'h01);
    end
    if (service_write_in && service_data_in == SERVICE_ARM) begin
      nxt_armed = 1'b1; // see R13
    end
  end

  // Counter state; the system reset returns everything to zero.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pre_ff <= 16'h0000;
      cnt_ff <= 7'h00;
      armed_ff <= 1'b0;
      timeout_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      armed_ff <= nxt_armed;
      timeout_ff <= nxt_timeout;
    end
  end

  assign timeout_out = timeout_ff;

  a_service_clear: assert property ( // see R13
    @(posedge clk_sys_in) disable iff (srst_in)
    clear_req |=> cnt_ff == 7'h00 && !armed_ff)
    else $error("armed clear did not zero the watchdog count");

  a_timeout_cause: assert property ( // see R12
    @(posedge clk_sys_in) disable iff (srst_in)
    timeout_out |-> $past(cnt_ff) == $past(limit) && $past(enable_in))
    else $error("watchdog timeout without reaching the rate limit");
endmodule

// ===== tb/ext_reset_model.sv
`timescale 1ns/10ps
module ext_reset_model (
  input wire logic clk_sys_in,
  input wire logic hold_in,
  output logic pin_oe_out
);
  // Open-drain pull-down with a sharp release, so an internal reset is never misread.
  always_ff @(posedge clk_sys_in) begin
    pin_oe_out <= hold_in;
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module testbench;
  import rst_pkg::*;
  logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, hold = 0, act = 0, act_en = 1;
  logic irq_n = 1, ack = 0, stop = 0, eq, special_mode_flag = 0;
  logic [7:0] addr = 0, nvm = 8'h84, nvd;
  logic [31:0] wd = 0, q;
  logic [31:0] rd;
  logic rdy, err, oe, pin_val, ext_oe, sys_rst, irq_req, cpwr, cclk, osc, nvw;
  logic [15:0] vec;
  int n_mismatch = 0, num_checks = 0, n;
  // The pin has a pull-up; either party pulling low wins.
  wire rst_pin_n = !((oe && !pin_val) || ext_oe);
  reset_watchdog_clock_monitor #(.WDG_PRESCALE(16)) dut_u (
    .clk_sys_in(clk), .srst_in(srst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(addr), .pwdata_in(wd), .prdata_out(rd), .pready_out(rdy), .pslverr_out(err),
    .reset_pin_in(rst_pin_n), .reset_pin_out(pin_val), .reset_pin_oe_out(oe),
    .special_mode_flag_in(special_mode_flag), .cpu_clk_activity_in(act), .stop_mode_in(stop),
    .irq_pin_in(irq_n), .irq_ack_in(ack), .nvm_config_in(nvm), .nvm_write_out(nvw),
    .nvm_write_data_out(nvd), .sys_reset_out(sys_rst), .reset_vector_out(vec),
    .converter_power_up_out(cpwr), .converter_clock_source_out(cclk),
    .irq_request_out(irq_req), .osc_hold_out(osc));
  ext_reset_model model_u (.clk_sys_in(clk), .hold_in(hold), .pin_oe_out(ext_oe));
  // Clock, and a guarded-clock activity signal that can be stopped.
  always #5 clk = ~clk;
  always @(posedge clk) if (act_en) act <= ~act;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic fail_wait();
    n_mismatch++;
    $display("[FAIL] wait bound exp 1 got 0");
    end_sim();
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Counts edges until a signal reaches a level; a bound keeps a hang from stalling the run.
  task automatic wait_on(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) fail_wait();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    q = rd;
    eq = err;
    if (k >= 20) fail_wait();
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK("read", {24'h0, e}, q)
  endtask
  task automatic t_por();
    wait_on(oe, 1'b1, 4100);
    `CHK("por", 1'b1, n >= 4063 && n <= 4066)
    wait_on(oe, 1'b0, 10);
    `CHK("drive", 4, n)
    wait_on(sys_rst, 1'b0, 20);
    `CHK("vec", VEC_NORM_PIN, vec)
  endtask
  task automatic t_regs();
    rdc(ADDR_OPTIONS, OPTIONS_RESET);
    rdc(ADDR_CONFIG, 8'he4);
    apb(1'b0, 8'h00, 8'h00);
    `CHK("unmapped", 1'b1, eq)
    apb(1'b1, ADDR_CONFIG, 8'h3c);
    `CHK("nvm write", 9'h13c, {nvw, nvd})
    rdc(ADDR_CONFIG, 8'he4);
  endtask
  // Level mode drops the request with the pin; edge mode keeps it until acknowledged.
  task automatic t_irq(input logic edg);
    irq_n <= 1'b0;
    cyc(6);
    `CHK("irq low", 1'b1, irq_req)
    irq_n <= 1'b1;
    cyc(6);
    `CHK("irq high", edg, irq_req)
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(3);
    `CHK("irq ack", 1'b0, irq_req)
  endtask
  task automatic t_option();
    apb(1'b1, ADDR_OPTIONS, 8'ha1);
    rdc(ADDR_OPTIONS, 8'ha1);
    apb(1'b1, ADDR_OPTIONS, 8'h4c);
    rdc(ADDR_OPTIONS, 8'h69);
    `CHK("conv", 2'b01, {cpwr, cclk})
  endtask
  task automatic t_ext();
    nvm <= 8'h80;
    hold <= 1'b1;
    wait_on(oe, 1'b1, 10);
    cyc(40);
    `CHK("ext hold", 1'b1, sys_rst)
    hold <= 1'b0;
    wait_on(sys_rst, 1'b0, 20);
    rdc(ADDR_STATUS, 8'h00);
    rdc(ADDR_OPTIONS, OPTIONS_RESET);
    rdc(ADDR_CONFIG, 8'he0);
  endtask
  // A read sits between arm and clear; the cause must stay at pin reset throughout.
  task automatic t_wdg();
    apb(1'b1, ADDR_OPTIONS, 8'h11);
    repeat (6) begin
      apb(1'b1, ADDR_SERVICE, SERVICE_ARM);
      rdc(ADDR_SERVICE, 8'h00);
      apb(1'b1, ADDR_SERVICE, SERVICE_CLEAR);
    end
    rdc(ADDR_STATUS, 8'h00);
    nvm <= 8'h84;
    wait_on(sys_rst, 1'b1, 100);
    `CHK("wdg time", 1'b1, n >= 62 && n <= 78)
    wait_on(sys_rst, 1'b0, 20);
    `CHK("vec", VEC_NORM_WDG, vec)
    rdc(ADDR_STATUS, 8'h02);
    rdc(ADDR_CONFIG, 8'he4);
  endtask
  task automatic t_cmon();
    apb(1'b1, ADDR_OPTIONS, 8'h0c);
    apb(1'b1, ADDR_OPTIONS, 8'h00);
    rdc(ADDR_OPTIONS, 8'h04);
    act_en <= 1'b0;
    wait_on(sys_rst, 1'b1, 1100);
    `CHK("cmon min", 1'b1, n >= 995)
    act_en <= 1'b1;
    wait_on(sys_rst, 1'b0, 20);
    `CHK("vec", VEC_NORM_CMON, vec)
    rdc(ADDR_STATUS, 8'h01);
  endtask
  task automatic t_stop();
    apb(1'b1, ADDR_OPTIONS, OPTIONS_RESET);
    stop <= 1'b1;
    cyc(2);
    stop <= 1'b0;
    wait_on(osc, 1'b1, 4);
    wait_on(osc, 1'b0, 4100);
    `CHK("stop dly", 1'b1, n >= 3999 && n <= 4001)
  endtask
  // Special mode: watchdog resets start inhibited and the latch takes writes directly.
  task automatic t_spec();
    special_mode_flag <= 1'b1;
    hold <= 1'b1;
    cyc(20);
    hold <= 1'b0;
    wait_on(sys_rst, 1'b0, 20);
    `CHK("vec", VEC_SPEC_PIN, vec)
    rdc(ADDR_STATUS, 8'h04);
    rdc(ADDR_TEST, 8'h01);
    apb(1'b1, ADDR_CONFIG, 8'h00);
    rdc(ADDR_CONFIG, 8'h60);
    cyc(48);
    `CHK("wdg inhibit", VEC_SPEC_PIN, vec)
  endtask
  // Reset, then the scenarios in an order that keeps the option window open for t_option.
  initial begin
    cyc(12);
    srst <= 1'b0;
    t_por();
    t_regs();
    t_irq(1'b0);
    t_option();
    t_irq(1'b1);
    t_ext();
    t_wdg();
    t_cmon();
    t_stop();
    t_spec();
    end_sim();
  end
endmodule
